// ==== dcc_defines.vh ====
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
// core clock rate in Hz
`define DCC_CLK_HZ 125000000
// chopping frequency in Hz (nominal 26.5 kHz, kept in tenths of Hz)
`define DCC_CHOP_DHZ 265000
// chopping period in core cycles, rounded down
`define DCC_CHOP_CYC ((`DCC_CLK_HZ * 10) / `DCC_CHOP_DHZ)
// dead time on direction change in ns, and cycles rounded up
`define DCC_DEAD_NS 1000
`define DCC_DEAD_CYC ((`DCC_DEAD_NS * (`DCC_CLK_HZ / 1000000) + 999) / 1000)
`define DCC_CNT_W 16

// ----------------------------------------
// analog scaling
// ----------------------------------------
// reference and sense codes share one scale; trip = ref * 18 / 100
`define DCC_CODE_W 12
`define DCC_TRIP_NUM 8'h12
`define DCC_TRIP_DEN 8'h64

// ----------------------------------------
// thermal
// ----------------------------------------
`define DCC_TEMP_W 9
`define DCC_TSD_ON_C 9'h0A0
`define DCC_TSD_HYST_C 9'h014

// ----------------------------------------
// bridge leg encoding on o_bridge_ch* [3:0] = {a_hi, a_lo, b_hi, b_lo}
// ----------------------------------------
`define DCC_LEG_OFF 4'h0
`define DCC_LEG_A_TO_B 4'h9
`define DCC_LEG_B_TO_A 4'h6

`endif

// ==== dcc_chopper.v ====
`include "dcc_defines.vh"

module dcc_chopper (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_ce,
	input wire [1:0] i_direction,
	input wire [`DCC_CODE_W-1:0] i_ref_ch1,
	input wire [`DCC_CODE_W-1:0] i_ref_ch2,
	input wire [`DCC_CODE_W-1:0] i_sense_ch1,
	input wire [`DCC_CODE_W-1:0] i_sense_ch2,
	input wire [`DCC_TEMP_W-1:0] i_die_temp_c,
	output reg [3:0] o_bridge_ch1,
	output reg [3:0] o_bridge_ch2,
	output reg o_osc_tick,
	output reg o_thermal_shutdown
);

	// ----------------------------------------
	// constants
	// ----------------------------------------
	// whole-number copies, so the narrow counter constants are cut on purpose
	// dead time is at least one cycle even if the macro rounds down to zero
	localparam integer CHOP_CYC_I = `DCC_CHOP_CYC;
	localparam integer DEAD_CYC_I = (`DCC_DEAD_CYC < 1) ? 1 : `DCC_DEAD_CYC;
	localparam [`DCC_CNT_W-1:0] CHOP_LAST = CHOP_CYC_I[`DCC_CNT_W-1:0] - {{(`DCC_CNT_W-1){1'b0}}, 1'b1};
	localparam [`DCC_CNT_W-1:0] DEAD_CYC = DEAD_CYC_I[`DCC_CNT_W-1:0];
	localparam [`DCC_TEMP_W-1:0] TSD_ON = `DCC_TSD_ON_C;
	localparam [`DCC_TEMP_W-1:0] TSD_OFF = `DCC_TSD_ON_C - `DCC_TSD_HYST_C;

	// ----------------------------------------
	// per-channel states
	// ----------------------------------------
	localparam [1:0] ST_OFF = 2'h0;
	localparam [1:0] ST_DEAD = 2'h1;
	localparam [1:0] ST_ON = 2'h2;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function [`DCC_CODE_W+4:0] trip_level;
		input [`DCC_CODE_W-1:0] ref_code;
		reg [`DCC_CODE_W+7:0] prod;
		begin
			prod = ref_code * `DCC_TRIP_NUM;
			trip_level = prod[`DCC_CODE_W+4:0];
		end
	endfunction

	function [3:0] leg_drive;
		input dir;
		begin
			leg_drive = dir ? `DCC_LEG_A_TO_B : `DCC_LEG_B_TO_A;
		end
	endfunction

	// sense scaled by 100 against ref scaled by 18, so no divider is needed
	function trip_hit;
		input [`DCC_CODE_W-1:0] sense_code;
		input [`DCC_CODE_W-1:0] ref_code;
		reg [`DCC_CODE_W+7:0] sense_x;
		begin
			sense_x = sense_code * `DCC_TRIP_DEN;
			trip_hit = (sense_x >= {3'h0, trip_level(ref_code)});
		end
	endfunction

	// ----------------------------------------
	// shared oscillator
	// ----------------------------------------
	reg [`DCC_CNT_W-1:0] osc_cnt_ff;
	reg [`DCC_CNT_W-1:0] nxt_osc_cnt;
	reg tick;

	// free running: the wrap is the one shared trigger for both latches
	// o_osc_tick shows it one cycle late, beside the bridge codes it sets
	always @* begin
		tick = (osc_cnt_ff == CHOP_LAST);
		if (tick) begin
			nxt_osc_cnt = {`DCC_CNT_W{1'b0}};
		end else begin
			nxt_osc_cnt = osc_cnt_ff + {{(`DCC_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			osc_cnt_ff <= {`DCC_CNT_W{1'b0}};
			o_osc_tick <= 1'b0;
		end else if (i_ce) begin
			osc_cnt_ff <= nxt_osc_cnt;
			o_osc_tick <= tick;
		end
	end

	// ----------------------------------------
	// thermal shutdown with hysteresis
	// ----------------------------------------
	reg nxt_tsd;

	// limits kept apart so a die near the trip point does not chatter
	always @* begin
		nxt_tsd = o_thermal_shutdown;
		if (i_die_temp_c > TSD_ON) begin
			nxt_tsd = 1'b1;
		end else if (i_die_temp_c <= TSD_OFF) begin
			nxt_tsd = 1'b0;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_rst) begin
			o_thermal_shutdown <= 1'b0;
		end else if (i_ce) begin
			o_thermal_shutdown <= nxt_tsd;
		end
	end

	// ----------------------------------------
	// channel latches
	// ----------------------------------------
	wire [`DCC_CODE_W-1:0] ref_v [0:1];
	wire [`DCC_CODE_W-1:0] sense_v [0:1];
	wire [7:0] nxt_bridge_v;
	assign ref_v[0] = i_ref_ch1;
	assign ref_v[1] = i_ref_ch2;
	assign sense_v[0] = i_sense_ch1;
	assign sense_v[1] = i_sense_ch2;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			reg [1:0] state_ff;
			reg [1:0] nxt_state;
			reg dir_ff;
			reg [`DCC_CNT_W-1:0] dead_ff;
			reg [`DCC_CNT_W-1:0] nxt_dead;
			reg [3:0] nxt_drive;
			wire trip = trip_hit(sense_v[ch], ref_v[ch]);
			wire dir_chg = (i_direction[ch] != dir_ff);

			always @* begin
				nxt_state = state_ff;
				nxt_dead = dead_ff;
				case (state_ff)
					ST_OFF: begin
						// reset dominates: a trip still asserted at the tick keeps the leg off
						if (tick && !trip) begin
							nxt_state = ST_ON;
						end
					end
					ST_DEAD: begin
						// counts down to one, then waits dark for a fresh trigger
						if (dead_ff > 1) begin
							nxt_dead = dead_ff - 1'b1;
						end else begin
							nxt_state = ST_OFF;
						end
					end
					ST_ON: begin
						if (trip) begin
							nxt_state = ST_OFF;
						end
					end
					default: nxt_state = ST_OFF;
				endcase
				if (dir_chg) begin
					// both legs dark for the dead time; waits for next tick after it
					nxt_state = ST_DEAD;
					nxt_dead = DEAD_CYC;
				end
				if (o_thermal_shutdown) begin
					nxt_state = ST_OFF;
				end
				nxt_drive = (nxt_state == ST_ON) ? leg_drive(i_direction[ch]) : `DCC_LEG_OFF;
			end

			always @(posedge i_core_clk) begin
				if (i_rst) begin
					state_ff <= ST_OFF;
					// a high direction at release costs one dead time first
					dir_ff <= 1'b0;
					dead_ff <= {`DCC_CNT_W{1'b0}};
				end else if (i_ce) begin
					state_ff <= nxt_state;
					dir_ff <= i_direction[ch];
					dead_ff <= nxt_dead;
				end
			end

			assign nxt_bridge_v[ch*4 +: 4] = nxt_drive;
		end
	endgenerate

	// ----------------------------------------
	// bridge outputs
	// ----------------------------------------
	// each bridge pin comes straight from a flop, so no decode glitch reaches the legs
	// reset loads the off code on both channels
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			o_bridge_ch1 <= `DCC_LEG_OFF;
			o_bridge_ch2 <= `DCC_LEG_OFF;
		end else if (i_ce) begin
			o_bridge_ch1 <= nxt_bridge_v[3:0];
			o_bridge_ch2 <= nxt_bridge_v[7:4];
		end
	end

endmodule // dcc_chopper

// ==== dcc_chk_asserts.sv ====
module dcc_chk (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_ce,
	input wire [1:0] i_direction,
	input wire [11:0] i_ref_ch1,
	input wire [11:0] i_ref_ch2,
	input wire [11:0] i_sense_ch1,
	input wire [11:0] i_sense_ch2,
	input wire [8:0] i_die_temp_c,
	input wire [3:0] o_bridge_ch1,
	input wire [3:0] o_bridge_ch2,
	input wire o_osc_tick,
	input wire o_thermal_shutdown
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst || !i_ce);
	wire t1 = 20'(i_sense_ch1) * 20'h64 >= 20'(i_ref_ch1) * 20'h12;
	wire t2 = 20'(i_sense_ch2) * 20'h64 >= 20'(i_ref_ch2) * 20'h12;
	reg [12:0] n_ff;
	reg seen_ff;
	// cycles since last tick; only judged once a first tick has anchored it
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			n_ff <= 13'h0000;
			seen_ff <= 1'b0;
		end else if (i_ce) begin
			n_ff <= o_osc_tick ? 13'h0000 : n_ff + 13'h0001;
			seen_ff <= seen_ff | o_osc_tick;
		end
	end
	tick_period_a: assert property (seen_ff |-> (o_osc_tick ? n_ff == 13'h126B : n_ff < 13'h126B))
		else $error("tick spacing wrong");
	set_on_tick_a: assert property (($rose(|o_bridge_ch1) || $rose(|o_bridge_ch2)) |-> o_osc_tick)
		else $error("bridge on without tick");
	trip_one_a: assert property ((|o_bridge_ch1 && t1) |=> o_bridge_ch1 == 4'h0)
		else $error("ch1 not off at trip");
	trip_two_a: assert property ((|o_bridge_ch2 && t2) |=> o_bridge_ch2 == 4'h0)
		else $error("ch2 not off at trip");
	trip_wins_a: assert property (o_osc_tick && $past(t1) |-> o_bridge_ch1 == 4'h0)
		else $error("ch1 on while tripped");
	leg_code_a: assert property (|o_bridge_ch1 |-> o_bridge_ch1 == ($past(i_direction[0], 2) ? 4'h9 : 4'h6))
		else $error("ch1 leg code wrong");
	dead_gap_a: assert property ($changed(i_direction[0]) |-> ##2 (o_bridge_ch1 == 4'h0) [*8])
		else $error("ch1 on during dead time");
	tsd_flag_a: assert property (!$past(i_rst) |-> o_thermal_shutdown == ($past(i_die_temp_c) > 9'h0A0 ||
		$past(o_thermal_shutdown) && $past(i_die_temp_c) > 9'h08C))
		else $error("shutdown flag wrong");
	tsd_off_a: assert property (o_thermal_shutdown |=> o_bridge_ch1 == 4'h0 && o_bridge_ch2 == 4'h0)
		else $error("bridge on in shutdown");
	cover property (o_osc_tick ##1 |o_bridge_ch1);
	cover property ($fell(|o_bridge_ch1));
	cover property ($rose(o_thermal_shutdown));
endmodule // dcc_chk

bind dcc_chopper dcc_chk u_chk (.i_core_clk, .i_rst, .i_ce, .i_direction, .i_ref_ch1, .i_ref_ch2, .i_sense_ch1,
	.i_sense_ch2, .i_die_temp_c, .o_bridge_ch1, .o_bridge_ch2, .o_osc_tick, .o_thermal_shutdown);

// ==== dcc_winding_model.sv ====
module dcc_winding_model (
	input wire i_core_clk,
	input wire [3:0] i_bridge,
	output reg [11:0] o_sense
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_sense = 12'h000;
	// steep rise, slow decay: duty stays far under half a period
	always @(posedge i_core_clk) begin
		if (i_bridge != 4'h0) o_sense <= o_sense + 12'h004;
		else if (o_sense != 12'h000) o_sense <= o_sense - 12'h001;
	end
endmodule // dcc_winding_model

// ==== tb_dual_chopper_current_control.sv ====
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_dual_chopper_current_control;
	timeunit 1ns;
	timeprecision 1ns;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [1:0] dir = 2'h1;
	reg [11:0] r1 = 12'h3E8;
	reg [8:0] tmp = 9'h019;
	wire [11:0] s1, s2;
	wire [3:0] b1, b2;
	wire tk, sd;
	int fails = 0, n_checks = 0, cyc = 0;
	initial forever #4 clk = ~clk;
	dcc_chopper u_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_direction(dir), .i_ref_ch1(r1),
		.i_ref_ch2(12'h3E8), .i_sense_ch1(s1), .i_sense_ch2(s2), .i_die_temp_c(tmp), .o_bridge_ch1(b1),
		.o_bridge_ch2(b2), .o_osc_tick(tk), .o_thermal_shutdown(sd));
	dcc_winding_model u_w1 (.i_core_clk(clk), .i_bridge(b1), .o_sense(s1));
	dcc_winding_model u_w2 (.i_core_clk(clk), .i_bridge(b2), .o_sense(s2));
	task st(int k); repeat (k) @(posedge clk); #1; endtask
	task tick; do st(1); while (tk !== 1'b1); endtask
	task t_chop; int n; tick; `CHK(b1, 4'h9) `CHK(b2, 4'h6)
		n = 0; do begin st(1); n++; end while (tk !== 1'b1); `CHK(n, 32'h0000126C)
		do st(1); while (b1 !== 4'h0); `CHK(s1 >= 12'h0B4 && s1 <= 12'h0BE, 1'b1)
		$display("chop done");
	endtask
	task t_hold; @(posedge clk) r1 <= 12'h000; tick; st(9);
		`CHK(b1, 4'h0) `CHK(b2, 4'h6)
		@(posedge clk) r1 <= 12'h3E8; $display("hold done");
	endtask
	// flip just before a tick so that tick lands inside the dead time
	task t_dead; tick; st(4650); @(posedge clk) dir <= 2'h0; tick; `CHK(b1, 4'h0)
		tick; `CHK(b1, 4'h6) $display("dead done");
	endtask
	task t_tsd; @(posedge clk) tmp <= 9'h0A0; st(3); `CHK(sd, 1'b0)
		@(posedge clk) tmp <= 9'h0A1; tick; `CHK(sd, 1'b1) `CHK(b1, 4'h0) `CHK(b2, 4'h0)
		@(posedge clk) tmp <= 9'h08D; st(3); `CHK(sd, 1'b1)
		@(posedge clk) tmp <= 9'h08C; st(3); `CHK(sd, 1'b0)
		tick; `CHK(b1, 4'h6) $display("tsd done");
	endtask
	task end_of_test; $display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 45000) begin
			fails++;
			end_of_test;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_chop; t_hold; t_dead; t_tsd;
		end_of_test;
	end
endmodule // tb_dual_chopper_current_control
